/* File: inc/bbd_defs.svh */
`ifndef BBD_DEFS_SVH
`define BBD_DEFS_SVH
`define BBD_OP_NOP 8'h00
`define BBD_OP_CLR_C 8'hC3
`define BBD_OP_CLR_BIT 8'hC2
`define BBD_OP_SET_C 8'hD3
`define BBD_OP_SET_BIT 8'hD2
`define BBD_OP_INV_C 8'hB3
`define BBD_OP_INV_BIT 8'hB2
`define BBD_OP_AND_BIT 8'h82
`define BBD_OP_AND_NBIT 8'hB0
`define BBD_OP_OR_BIT 8'h72
`define BBD_OP_CPY_BIT 8'hA2
`define BBD_OP_WR_BIT 8'h92
`define BBD_OP_FAR_CALL 8'h12
`define BBD_OP_FAR_JUMP 8'h02
`define BBD_OP_RTN 8'h22
`define BBD_OP_ISR_RTN 8'h32
`define BBD_OP_NEAR 8'h80
`define BBD_OP_IND_JUMP 8'h73
`define BBD_OP_ACC_Z 8'h60
`define BBD_OP_ACC_NZ 8'h70
`define BBD_OP_CY_SET 8'h40
`define BBD_OP_CY_CLR 8'h50
`define BBD_OP_BIT_SET 8'h20
`define BBD_OP_BIT_CLR 8'h30
`define BBD_OP_BIT_SETCLR 8'h10
`define BBD_OP_CMP_DIR 8'hB5
`define BBD_OP_CMP_IMM 8'hB4
`define BBD_OP_DEC_DIR 8'hD5
`define BBD_PAGE_LOW 4'h1
`define BBD_PAGE_LOW_F 3:0
`define BBD_PAGE_HI_F 7:5
`define BBD_PAGE_CALL_B 4
`define BBD_PAGE_KEEP_F 15:11
`define BBD_STAR_F 7:3
`define BBD_STAR_REG_F 2:0
`define BBD_CMP_REG 5'h17
`define BBD_DEC_REG 5'h1B
`define BBD_CMP_IND 7'h5B
`define BBD_CMP_IND_F 7:1
`define BBD_LEN1 2'h1
`define BBD_LEN2 2'h2
`define BBD_LEN3 2'h3
`define BBD_BYTE_ZERO 8'h00
`define BBD_BYTE_ONE 8'h01
`endif

/* File: inc/bbd_pkg.sv */
package bbd_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_CYC1 = 3'h2,
		ST_CYC2 = 3'h4
	} bbd_state_type;
	typedef enum logic [1:0] {
		SEL_NONE = 2'h0,
		SEL_DIRECT = 2'h1,
		SEL_WREG = 2'h2,
		SEL_INDIRECT = 2'h3
	} bbd_sel_type;
endpackage

/* File: src/bbd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bbd_defs.svh"
module bbd_decoder #(
	parameter logic [7:0] OP_OR_NBIT = 8'hA0
) (
	input wire logic ref_clk, // Core clock, 10 MHz
	input wire logic srst, // Synchronous reset, high
	input wire logic instr_valid, // Fetch unit offers an instruction
	input wire logic [7:0] op_byte, // First instruction byte
	input wire logic [7:0] arg1_byte, // Second instruction byte
	input wire logic [7:0] arg2_byte, // Third instruction byte
	input wire logic [15:0] next_pc, // Address of following instruction
	input wire logic [7:0] acc_in, // Accumulator
	input wire logic carry_in, // Carry flag
	input wire logic bit_in, // Addressed direct bit
	input wire logic [7:0] operand_in, // Byte picked by operand_sel
	input wire logic [15:0] data_pointer_register_in, // Data pointer register
	input wire logic [15:0] ret_addr_in, // Return address off the stack
	output logic instr_ready, // Decoder idle, takes instr_valid
	output logic [1:0] instr_len, // Length of taken instruction
	output logic two_cycle, // Taken instruction needs two cycles
	output bbd_pkg::bbd_sel_type operand_sel, // Source of operand_in
	output logic [2:0] reg_index, // Working or pointer register
	output logic [7:0] operand_addr, // Direct byte or bit address
	output logic done, // Results below valid, one cycle
	output logic illegal_op, // Opcode outside this group
	output logic carry_we, // Write carry_out to carry flag
	output logic carry_out, // New carry value
	output logic bit_we, // Write bit_out to addressed bit
	output logic bit_out, // New bit value
	output logic byte_we, // Write byte_out back to operand
	output logic [7:0] byte_out, // Decremented byte
	output logic pc_load, // Load pc_target into program counter
	output logic [15:0] pc_target, // Branch target
	output logic push_ret, // Push next_pc, call taken
	output logic pop_ret, // Return address consumed
	output logic isr_exit_done // Interrupt service exit retired
);
	// The idle opcode must stay the idle opcode
	if (OP_OR_NBIT == `BBD_OP_NOP) begin : g_chk
		$error("bbd_decoder: OP_OR_NBIT collides with idle");
	end

	bbd_pkg::bbd_state_type state_r, state_nxt;
	bbd_pkg::bbd_sel_type sel_r, sel_nxt;
	logic [7:0] op_r, op_nxt, a1_r, a1_nxt, a2_r, a2_nxt;
	logic [15:0] npc_r, npc_nxt;
	logic [1:0] len_r, len_nxt;
	logic two_r, two_nxt, ill_r, ill_nxt;
	logic [2:0] ridx_r, ridx_nxt;
	logic done_r, done_nxt, cwe_r, cwe_nxt, cy_r, cy_nxt;
	logic bwe_r, bwe_nxt, bo_r, bo_nxt, ywe_r, ywe_nxt;
	logic [7:0] yo_r, yo_nxt;
	logic pl_r, pl_nxt, push_r, push_nxt, pop_r, pop_nxt;
	logic isr_r, isr_nxt;
	logic [15:0] pt_r, pt_nxt;

	// Execute-stage helpers
	logic last;
	logic [7:0] rel, cmp_a, dec;
	logic [15:0] br_tgt;
	logic is_page, is_creg, is_cind, is_dreg;

	assign instr_ready = (state_r == bbd_pkg::ST_IDLE);
	assign instr_len = len_r;
	assign two_cycle = two_r;
	assign operand_sel = sel_r;
	assign reg_index = ridx_r;
	assign operand_addr = a1_r;
	assign done = done_r;
	assign illegal_op = ill_r;
	assign carry_we = cwe_r;
	assign carry_out = cy_r;
	assign bit_we = bwe_r;
	assign bit_out = bo_r;
	assign byte_we = ywe_r;
	assign byte_out = yo_r;
	assign pc_load = pl_r;
	assign pc_target = pt_r;
	assign push_ret = push_r;
	assign pop_ret = pop_r;
	assign isr_exit_done = isr_r;

	// Decode on accept, execute on the last cycle, result pulse after
	always_comb begin
		state_nxt = state_r;
		sel_nxt = sel_r;
		op_nxt = op_r;
		a1_nxt = a1_r;
		a2_nxt = a2_r;
		npc_nxt = npc_r;
		len_nxt = len_r;
		two_nxt = two_r;
		ill_nxt = ill_r;
		ridx_nxt = ridx_r;
		done_nxt = 1'b0;
		cwe_nxt = 1'b0;
		cy_nxt = cy_r;
		bwe_nxt = 1'b0;
		bo_nxt = bo_r;
		ywe_nxt = 1'b0;
		yo_nxt = yo_r;
		pl_nxt = 1'b0;
		pt_nxt = pt_r;
		push_nxt = 1'b0;
		pop_nxt = 1'b0;
		isr_nxt = 1'b0;
		last = 1'b0;
		// Pattern groups share one decode each
		is_page = (op_r[`BBD_PAGE_LOW_F] == `BBD_PAGE_LOW);
		is_creg = (op_r[`BBD_STAR_F] == `BBD_CMP_REG);
		is_cind = (op_r[`BBD_CMP_IND_F] == `BBD_CMP_IND);
		is_dreg = (op_r[`BBD_STAR_F] == `BBD_DEC_REG);
		// Three-byte branches carry rel in the third byte
		rel = (len_r == `BBD_LEN3) ? a2_r : a1_r;
		br_tgt = npc_r + 16'($signed(rel));
		cmp_a = (is_creg || is_cind) ? operand_in : acc_in;
		dec = operand_in - `BBD_BYTE_ONE;
		case (state_r)
			bbd_pkg::ST_IDLE: begin
				if (instr_valid) begin
					state_nxt = bbd_pkg::ST_CYC1;
					op_nxt = op_byte;
					a1_nxt = arg1_byte;
					a2_nxt = arg2_byte;
					npc_nxt = next_pc;
					ill_nxt = 1'b0;
					sel_nxt = bbd_pkg::SEL_NONE;
					ridx_nxt = op_byte[`BBD_STAR_REG_F];
					len_nxt = `BBD_LEN2;
					two_nxt = 1'b1;
					if (op_byte[`BBD_PAGE_LOW_F] == `BBD_PAGE_LOW) begin
						len_nxt = `BBD_LEN2;
					end else if (op_byte[`BBD_STAR_F] == `BBD_CMP_REG) begin
						len_nxt = `BBD_LEN3;
						sel_nxt = bbd_pkg::SEL_WREG;
					end else if (op_byte[`BBD_STAR_F] == `BBD_DEC_REG) begin
						sel_nxt = bbd_pkg::SEL_WREG;
					end else if (op_byte[`BBD_CMP_IND_F] == `BBD_CMP_IND) begin
						len_nxt = `BBD_LEN3;
						sel_nxt = bbd_pkg::SEL_INDIRECT;
					end else if (op_byte == OP_OR_NBIT) begin
						two_nxt = 1'b1;
					end else begin
						case (op_byte)
							`BBD_OP_CLR_C, `BBD_OP_SET_C, `BBD_OP_INV_C,
							`BBD_OP_NOP: begin
								len_nxt = `BBD_LEN1;
								two_nxt = 1'b0;
							end
							`BBD_OP_CLR_BIT, `BBD_OP_SET_BIT, `BBD_OP_INV_BIT,
							`BBD_OP_CPY_BIT: begin
								two_nxt = 1'b0;
							end
							`BBD_OP_AND_BIT, `BBD_OP_AND_NBIT, `BBD_OP_OR_BIT,
							`BBD_OP_WR_BIT, `BBD_OP_NEAR, `BBD_OP_ACC_Z,
							`BBD_OP_ACC_NZ, `BBD_OP_CY_SET,
							`BBD_OP_CY_CLR: begin
								len_nxt = `BBD_LEN2;
							end
							`BBD_OP_FAR_CALL, `BBD_OP_FAR_JUMP, `BBD_OP_BIT_SET,
							`BBD_OP_BIT_CLR, `BBD_OP_BIT_SETCLR,
							`BBD_OP_CMP_IMM: begin
								len_nxt = `BBD_LEN3;
							end
							`BBD_OP_CMP_DIR, `BBD_OP_DEC_DIR: begin
								len_nxt = `BBD_LEN3;
								sel_nxt = bbd_pkg::SEL_DIRECT;
							end
							`BBD_OP_RTN, `BBD_OP_ISR_RTN,
							`BBD_OP_IND_JUMP: begin
								len_nxt = `BBD_LEN1;
							end
							default: begin
								// Other groups retire at once, flagged
								len_nxt = `BBD_LEN1;
								two_nxt = 1'b0;
								ill_nxt = 1'b1;
							end
						endcase
					end
				end
			end
			bbd_pkg::ST_CYC1: begin
				if (two_r) begin
					state_nxt = bbd_pkg::ST_CYC2;
				end else begin
					state_nxt = bbd_pkg::ST_IDLE;
					last = 1'b1;
				end
			end
			bbd_pkg::ST_CYC2: begin
				state_nxt = bbd_pkg::ST_IDLE;
				last = 1'b1;
			end
			default: begin
				state_nxt = bbd_pkg::ST_IDLE;
			end
		endcase
		// Operands are sampled only on the last cycle, so a slow datapath
		// read has the whole instruction time to settle
		if (last) begin
			done_nxt = 1'b1;
			pt_nxt = br_tgt;
			if (is_page) begin
				pl_nxt = 1'b1;
				pt_nxt = {npc_r[`BBD_PAGE_KEEP_F], op_r[`BBD_PAGE_HI_F],
					a1_r};
				push_nxt = op_r[`BBD_PAGE_CALL_B];
			end else if (is_creg || is_cind) begin
				pl_nxt = (cmp_a != a1_r);
				cwe_nxt = 1'b1;
				cy_nxt = (cmp_a < a1_r);
			end else if (is_dreg) begin
				ywe_nxt = 1'b1;
				yo_nxt = dec;
				pl_nxt = (dec != `BBD_BYTE_ZERO);
			end else if (op_r == OP_OR_NBIT) begin
				cwe_nxt = 1'b1;
				cy_nxt = carry_in | ~bit_in;
			end else begin
				case (op_r)
					`BBD_OP_CLR_C: begin
						cwe_nxt = 1'b1;
						cy_nxt = 1'b0;
					end
					`BBD_OP_SET_C: begin
						cwe_nxt = 1'b1;
						cy_nxt = 1'b1;
					end
					`BBD_OP_INV_C: begin
						cwe_nxt = 1'b1;
						cy_nxt = ~carry_in;
					end
					`BBD_OP_CLR_BIT: begin
						bwe_nxt = 1'b1;
						bo_nxt = 1'b0;
					end
					`BBD_OP_SET_BIT: begin
						bwe_nxt = 1'b1;
						bo_nxt = 1'b1;
					end
					`BBD_OP_INV_BIT: begin
						bwe_nxt = 1'b1;
						bo_nxt = ~bit_in;
					end
					`BBD_OP_AND_BIT: begin
						cwe_nxt = 1'b1;
						cy_nxt = carry_in & bit_in;
					end
					`BBD_OP_AND_NBIT: begin
						cwe_nxt = 1'b1;
						cy_nxt = carry_in & ~bit_in;
					end
					`BBD_OP_OR_BIT: begin
						cwe_nxt = 1'b1;
						cy_nxt = carry_in | bit_in;
					end
					`BBD_OP_CPY_BIT: begin
						cwe_nxt = 1'b1;
						cy_nxt = bit_in;
					end
					`BBD_OP_WR_BIT: begin
						bwe_nxt = 1'b1;
						bo_nxt = carry_in;
					end
					`BBD_OP_FAR_CALL, `BBD_OP_FAR_JUMP: begin
						pl_nxt = 1'b1;
						pt_nxt = {a1_r, a2_r};
						push_nxt = (op_r == `BBD_OP_FAR_CALL);
					end
					`BBD_OP_RTN, `BBD_OP_ISR_RTN: begin
						pl_nxt = 1'b1;
						pt_nxt = ret_addr_in;
						pop_nxt = 1'b1;
						isr_nxt = (op_r == `BBD_OP_ISR_RTN);
					end
					`BBD_OP_NEAR: pl_nxt = 1'b1;
					`BBD_OP_IND_JUMP: begin
						pl_nxt = 1'b1;
						pt_nxt = data_pointer_register_in + {8'h00, acc_in};
					end
					`BBD_OP_ACC_Z: pl_nxt = (acc_in == `BBD_BYTE_ZERO);
					`BBD_OP_ACC_NZ: pl_nxt = (acc_in != `BBD_BYTE_ZERO);
					`BBD_OP_CY_SET: pl_nxt = carry_in;
					`BBD_OP_CY_CLR: pl_nxt = ~carry_in;
					`BBD_OP_BIT_SET: pl_nxt = bit_in;
					`BBD_OP_BIT_CLR: pl_nxt = ~bit_in;
					`BBD_OP_BIT_SETCLR: begin
						pl_nxt = bit_in;
						bwe_nxt = bit_in;
						bo_nxt = 1'b0;
					end
					`BBD_OP_CMP_DIR, `BBD_OP_CMP_IMM: begin
						// Direct form compares against operand_in
						pl_nxt = (op_r == `BBD_OP_CMP_DIR) ?
							(acc_in != operand_in) : (acc_in != a1_r);
						cwe_nxt = 1'b1;
						cy_nxt = (op_r == `BBD_OP_CMP_DIR) ?
							(acc_in < operand_in) : (acc_in < a1_r);
					end
					`BBD_OP_DEC_DIR: begin
						ywe_nxt = 1'b1;
						yo_nxt = dec;
						pl_nxt = (dec != `BBD_BYTE_ZERO);
					end
					default: begin
						pl_nxt = 1'b0;
					end
				endcase
			end
		end
	end

	// Register every piece of decoder state
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_r <= bbd_pkg::ST_IDLE;
			sel_r <= bbd_pkg::SEL_NONE;
			op_r <= `BBD_OP_NOP;
			a1_r <= `BBD_BYTE_ZERO;
			a2_r <= `BBD_BYTE_ZERO;
			npc_r <= '0;
			len_r <= `BBD_LEN1;
			two_r <= 1'b0;
			ill_r <= 1'b0;
			ridx_r <= '0;
			done_r <= 1'b0;
			cwe_r <= 1'b0;
			cy_r <= 1'b0;
			bwe_r <= 1'b0;
			bo_r <= 1'b0;
			ywe_r <= 1'b0;
			yo_r <= `BBD_BYTE_ZERO;
			pl_r <= 1'b0;
			pt_r <= '0;
			push_r <= 1'b0;
			pop_r <= 1'b0;
			isr_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sel_r <= sel_nxt;
			op_r <= op_nxt;
			a1_r <= a1_nxt;
			a2_r <= a2_nxt;
			npc_r <= npc_nxt;
			len_r <= len_nxt;
			two_r <= two_nxt;
			ill_r <= ill_nxt;
			ridx_r <= ridx_nxt;
			done_r <= done_nxt;
			cwe_r <= cwe_nxt;
			cy_r <= cy_nxt;
			bwe_r <= bwe_nxt;
			bo_r <= bo_nxt;
			ywe_r <= ywe_nxt;
			yo_r <= yo_nxt;
			pl_r <= pl_nxt;
			pt_r <= pt_nxt;
			push_r <= push_nxt;
			pop_r <= pop_nxt;
			isr_r <= isr_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: dv/bbd_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module bbd_checker (
	input wire logic ref_clk, // Clock
	input wire logic srst, // Reset
	input wire logic instr_valid, // Offer
	input wire logic [7:0] op_byte, // Opcode
	input wire logic instr_ready, // Idle
	input wire logic done, // Result
	input wire logic carry_in, // Carry
	input wire logic bit_in, // Bit
	input wire logic carry_we, // Carry write
	input wire logic carry_out, // New carry
	input wire logic pc_load, // Branch
	input wire logic push_ret, // Push
	input wire logic pop_ret, // Pop
	input wire logic isr_exit_done // Isr exit
);
	// Accept edge; the opcode only counts here
	logic tk;
	assign tk = instr_valid && instr_ready;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// Result after one or two execute cycles
	sequence s_one;
		!done ##1 done;
	endsequence
	sequence s_two;
		!done[*2] ##1 done;
	endsequence
	a_set_carry: assert property (tk && op_byte == 8'hD3 |=>
		s_one ##0 (carry_we && carry_out)) else $error("set carry");
	a_and_carry: assert property (tk && op_byte == 8'h82 |=>
		s_two ##0 (carry_we && carry_out == ($past(carry_in) && $past(bit_in))))
		else $error("and carry");
	a_copy_bit: assert property (tk && op_byte == 8'hA2 |=>
		s_one ##0 (carry_we && carry_out == $past(bit_in)))
		else $error("copy bit");
	a_carry_jump: assert property (tk && op_byte == 8'h40 |=>
		s_two ##0 (pc_load == $past(carry_in))) else $error("carry jump");
	a_far_jump: assert property (tk && op_byte == 8'h02 |=>
		s_two ##0 (pc_load && !push_ret)) else $error("far jump");
	a_far_call: assert property (tk && op_byte == 8'h12 |=>
		s_two ##0 (pc_load && push_ret)) else $error("far call");
	a_isr_exit: assert property (tk && op_byte == 8'h32 |=>
		s_two ##0 (pop_ret && isr_exit_done)) else $error("isr exit");
	a_idle_op: assert property (tk && op_byte == 8'h00 |=>
		s_one ##0 !(carry_we || pc_load || pop_ret)) else $error("idle op");
endmodule
`default_nettype wire

/* File: dv/bbd_dp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bbd_dp_model (
	input wire logic ref_clk, // Clock
	input wire logic preset_en, // Load flags
	input wire logic preset_carry, // Carry to load
	input wire logic preset_bit, // Bit to load
	input wire logic carry_we, // Carry strobe
	input wire logic carry_out, // New carry
	input wire logic bit_we, // Bit strobe
	input wire logic bit_out, // New bit
	output logic carry_in, // Carry flag
	output logic bit_in // Addressed bit
);
	// Flags move only on strobes, so a lost write shows on the next op
	always_ff @(posedge ref_clk) begin
		if (preset_en) begin
			carry_in <= preset_carry;
			bit_in <= preset_bit;
		end else begin
			if (carry_we) carry_in <= carry_out;
			if (bit_we) bit_in <= bit_out;
		end
	end
endmodule
`default_nettype wire

/* File: dv/test_boolean_and_branch_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	miscompares++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_boolean_and_branch_decoder;
	logic ref_clk = '0, srst = 1'h1, instr_valid = '0;
	logic pre_en = '0, pre_c = '0, pre_b = '0;
	logic [7:0] op_byte = '0, arg1_byte = '0, arg2_byte = '0;
	logic [7:0] acc_in = '0, operand_in = '0, operand_addr, byte_out;
	logic [15:0] next_pc = '0, data_pointer_register_in = '0, ret_addr_in = '0, pc_target;
	logic instr_ready, two_cycle, done, illegal_op, carry_we, carry_out;
	logic bit_we, bit_out, byte_we, pc_load, push_ret, pop_ret;
	logic isr_exit_done, carry_in, bit_in;
	logic [1:0] instr_len;
	logic [2:0] reg_index;
	bbd_pkg::bbd_sel_type operand_sel;
	int miscompares = 0, n_compared = 0;
	// Core clock, 100 ns period
	always #50 ref_clk = ~ref_clk;
	bbd_decoder i_dut (.ref_clk, .srst, .instr_valid, .op_byte, .arg1_byte,
		.arg2_byte, .next_pc, .acc_in, .carry_in, .bit_in, .operand_in,
		.data_pointer_register_in, .ret_addr_in, .instr_ready, .instr_len, .two_cycle,
		.operand_sel, .reg_index, .operand_addr, .done, .illegal_op,
		.carry_we, .carry_out, .bit_we, .bit_out, .byte_we, .byte_out,
		.pc_load, .pc_target, .push_ret, .pop_ret, .isr_exit_done);
	bbd_dp_model i_dp (.ref_clk, .preset_en(pre_en), .preset_carry(pre_c),
		.preset_bit(pre_b), .carry_we, .carry_out, .bit_we, .bit_out,
		.carry_in, .bit_in);
	// One instruction; done awaited under a bound, then timing judged
	task automatic exec(input logic [7:0] op, a1, a2,
		input logic [1:0] el, input int ec);
		int n = 1;
		{instr_valid, op_byte, arg1_byte, arg2_byte} = {1'h1, op, a1, a2};
		@(posedge ref_clk);
		#10 instr_valid = 1'h0;
		`CHK("busy", 1'h0, instr_ready)
		while (done !== 1'h1 && n < 6) begin
			@(posedge ref_clk);
			#10 n++;
		end
		`CHK("cycles", ec, n)
		`CHK("length", {el, ec == 3}, {instr_len, two_cycle})
		`CHK("ready", 1'h1, instr_ready)
	endtask
	task automatic preset(input logic c, b);
		{pre_en, pre_c, pre_b} = {1'h1, c, b};
		@(posedge ref_clk);
		#10 pre_en = 1'h0;
	endtask
	// Flags chain from op to op, so invert sees the earlier writes
	task automatic t_bool;
		logic [7:0] ops[6] = '{8'hC3, 8'hD3, 8'hB3, 8'hC2, 8'hD2, 8'hB2};
		logic [3:0] ex[6] = '{4'h8, 4'hC, 4'h8, 4'h2, 4'h3, 4'h2};
		preset(1'h1, 1'h0);
		for (int i = 0; i < 6; i++) begin
			exec(ops[i], 8'h20, '0, i < 3 ? 2'h1 : 2'h2, 2);
			`CHK("flags", ex[i], {carry_we, carry_out, bit_we, bit_out})
		end
	endtask
	// Fresh flags per op; inverted forms must leave the bit alone
	task automatic t_logic;
		logic [7:0] ops[6] = '{8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92};
		logic [3:0] ex[6] = '{4'hC, 4'h8, 4'hC, 4'h8, 4'hC, 4'h7};
		logic [5:0] c = 6'h23, b = 6'h1F;
		for (int i = 0; i < 6; i++) begin
			preset(c[i], b[i]);
			exec(ops[i], 8'h21, '0, 2'h2, i == 4 ? 2 : 3);
			`CHK("logic", ex[i], {carry_we, carry_out, bit_we, bit_out})
		end
	endtask
	// Transfers issued back to back, no idle gap
	task automatic t_jump;
		{next_pc, acc_in, data_pointer_register_in} = {16'h1003, 8'h05, 16'h2000};
		ret_addr_in = 16'h4321;
		exec(8'h02, 8'h12, 8'h34, 2'h3, 3);
		`CHK("far jump", 18'h21234, {pc_load, push_ret, pc_target})
		exec(8'h12, 8'hAB, 8'hCD, 2'h3, 3);
		`CHK("far call", 18'h3ABCD, {pc_load, push_ret, pc_target})
		exec(8'h73, '0, '0, 2'h1, 3);
		`CHK("indirect", 17'h12005, {pc_load, pc_target})
		exec(8'h22, '0, '0, 2'h1, 3);
		`CHK("exit", 2'h2, {pop_ret, isr_exit_done})
		exec(8'h32, '0, '0, 2'h1, 3);
		`CHK("isr exit", 2'h3, {pop_ret, isr_exit_done})
		exec(8'h00, '0, '0, 2'h1, 2);
		`CHK("idle", 4'h0, {carry_we, bit_we, pc_load, byte_we})
		`CHK("legal", 1'h0, illegal_op)
		exec(8'h04, '0, '0, 2'h1, 2);
		`CHK("foreign", 3'h4, {illegal_op, carry_we, pc_load})
		`CHK("foreign wr", 2'h0, {bit_we, byte_we})
	endtask
	// Most negative displacement, accumulator zero, carry set
	task automatic t_rel;
		logic [7:0] ops[5] = '{8'h80, 8'h60, 8'h70, 8'h40, 8'h50};
		logic [4:0] tk = 5'h0B;
		logic [15:0] m;
		{next_pc, acc_in} = {16'h0102, 8'h00};
		preset(1'h1, 1'h0);
		for (int i = 0; i < 5; i++) begin
			m = {16{tk[i]}};
			exec(ops[i], 8'h80, '0, 2'h2, 3);
			`CHK("rel", {tk[i], 16'h0082 & m}, {pc_load, pc_target & m})
		end
	endtask
	// Bit branches; the last one also clears the bit
	task automatic t_bitbr;
		logic [7:0] ops[3] = '{8'h20, 8'h30, 8'h10};
		logic [2:0] ex[3] = '{3'h5, 3'h1, 3'h6};
		next_pc = 16'h0200;
		preset(1'h0, 1'h1);
		for (int i = 0; i < 3; i++) begin
			exec(ops[i], 8'h33, 8'h7F, 2'h3, 3);
			`CHK("bit br", ex[i], {pc_load, bit_we, bit_out})
		end
		`CHK("bit tgt", 24'h33027F, {operand_addr, pc_target})
	endtask
	// Every source kind; register equal, direct greater, immediate less, indirect less and greater
	task automatic t_cmp;
		logic [7:0] ops[6] = '{8'hB5, 8'hB4, 8'hBA, 8'hBF, 8'hB6, 8'hB7};
		logic [7:0] imm[6] = '{8'h44, 8'h30, 8'h10, 8'h10, 8'h05, 8'h11};
		logic [2:0] ex[6] = '{3'h6, 3'h7, 3'h2, 3'h2, 3'h6, 3'h7};
		logic [1:0] sel[6] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 2'h3};
		{next_pc, acc_in, operand_in} = {16'h0300, 8'h20, 8'h10};
		for (int i = 0; i < 6; i++) begin
			exec(ops[i], imm[i], 8'h10, 2'h3, 3);
			`CHK("cmp", ex[i], {pc_load, carry_we, carry_out})
			`CHK("src", {sel[i], ops[i][2:0]}, {operand_sel, reg_index})
		end
	endtask
	// Count down to zero stays put; wrap from zero branches
	task automatic t_dec;
		{next_pc, operand_in} = {16'h0400, 8'h01};
		exec(8'hDD, 8'hF0, '0, 2'h2, 3);
		`CHK("dec reg", 13'h1005, {byte_we, byte_out, pc_load, reg_index})
		operand_in = 8'h00;
		exec(8'hD5, 8'h40, 8'hF0, 2'h3, 3);
		`CHK("dec dir", 26'h3FF03F0, {byte_we, pc_load, byte_out, pc_target})
	endtask
	// Page targets keep the top five bits of the next address
	task automatic t_page;
		next_pc = 16'hF802;
		exec(8'hE1, 8'h55, '0, 2'h2, 3);
		`CHK("page jump", 18'h2FF55, {pc_load, push_ret, pc_target})
		exec(8'hF1, 8'hAA, '0, 2'h2, 3);
		`CHK("page call", 18'h3FFAA, {pc_load, push_ret, pc_target})
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		#10 srst = 1'h0;
		t_bool();
		t_logic();
		t_jump();
		t_rel();
		t_bitbr();
		t_cmp();
		t_dec();
		t_page();
		summarize();
	end
	// Hang guard, far beyond the roughly 120 cycles needed
	initial begin
		#300000;
		miscompares++;
		summarize();
	end
	task automatic summarize;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
endmodule
bind bbd_decoder bbd_checker i_chk (.ref_clk, .srst, .instr_valid, .op_byte,
	.instr_ready, .done, .carry_in, .bit_in, .carry_we, .carry_out, .pc_load,
	.push_ret, .pop_ret, .isr_exit_done);
`default_nettype wire
